// [rtl/ebr_bus_ctrl.v]
// External bus cycle controller with wait states, ready and Avalon-MM registers
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "ebr_regs.vh"
module ebr_bus_ctrl #(
    parameter ADDR_W = 24,
    parameter DATA_W = 16,
    parameter HALF_PERIOD_CYC = `EBR_HALF_PERIOD_CYC
) (
    input wire ref_clk,
    input wire rstn,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg bus_clock_output,
    output reg [ADDR_W-1:0] ext_addr,
    output reg [DATA_W-1:0] ext_data_out,
    output reg ext_data_oe_n,
    input wire [DATA_W-1:0] ext_data_in,
    output reg rd_n,
    output reg wr_n,
    output reg read_chip_select_n,
    output reg write_chip_select_n,
    output reg chip_select_line_n,
    input wire ready_n
);
    // Bus cycle states
    localparam [2:0] S_IDLE = 3'b000;
    localparam [2:0] S_ADDR = 3'b001;
    localparam [2:0] S_CMD = 3'b010;
    localparam [2:0] S_MUX = 3'b011;
    localparam [2:0] S_TRI = 3'b100;

    // Software registers
    reg [31:0] cfg;
    reg [ADDR_W-1:0] addr_reg;
    reg [DATA_W-1:0] wdata_reg;
    reg [DATA_W-1:0] rdata_reg;
    reg pend;
    reg pend_read;
    reg [7:0] rwait_last;

    // Cycle state
    reg [2:0] state;
    reg [3:0] wcnt;
    reg [7:0] rwait_cnt;
    reg cyc_read;
    reg cyc_rwd;
    reg cyc_mux;
    reg cyc_tri;
    reg cyc_rdyen;
    reg [3:0] cyc_wait;
    reg cmd_due;

    // Half-period divider
    reg [7:0] tcnt;
    wire tick = (tcnt == HALF_PERIOD_CYC[7:0] - 8'h01);
    wire rise_tick = tick & ~bus_clock_output;
    wire fall_tick = tick & bus_clock_output;

    // Synchronised pins
    wire ready_s;
    wire [DATA_W-1:0] data_s;

    ebr_sync #(.W(1), .RST_VAL(1'b1)) u_rdy_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .din(ready_n),
        .dout(ready_s)
    );

    ebr_sync #(.W(DATA_W), .RST_VAL({DATA_W{1'b0}})) u_data_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .din(ext_data_in),
        .dout(data_s)
    );

    // Bus access decode
    wire busy = pend | (state != S_IDLE);
    wire acc_wr = avs_write & ~avs_waitrequest;
    reg [31:0] rd_mux;

    // Read data selection
    always @* begin
        rd_mux = 32'h00000000;
        case (avs_address)
            `EBR_OFS_CFG: rd_mux = {24'h000000, cfg[7:0]};
            `EBR_OFS_ADDR: rd_mux[ADDR_W-1:0] = addr_reg;
            `EBR_OFS_WDATA: rd_mux[DATA_W-1:0] = wdata_reg;
            `EBR_OFS_RDATA: rd_mux[DATA_W-1:0] = rdata_reg;
            `EBR_OFS_STATUS: begin
                rd_mux[`EBR_ST_BUSY] = busy;
                rd_mux[`EBR_ST_PEND] = pend;
                rd_mux[`EBR_ST_RWAIT_MSB:`EBR_ST_RWAIT_LSB] = rwait_last;
            end
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Avalon slave: one wait cycle, then answer
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else if ((avs_read | avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rd_mux : 32'h00000000;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Register writes; a start while busy is ignored
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cfg <= `EBR_CFG_RST;
            addr_reg <= {ADDR_W{1'b0}};
            wdata_reg <= {DATA_W{1'b0}};
            pend <= 1'b0;
            pend_read <= 1'b0;
        end else begin
            if (state == S_IDLE && rise_tick && pend) begin
                pend <= 1'b0;
            end
            if (acc_wr) begin
                case (avs_address)
                    `EBR_OFS_CFG: cfg <= {24'h000000, avs_writedata[7:0]};
                    `EBR_OFS_ADDR: addr_reg <= avs_writedata[ADDR_W-1:0];
                    `EBR_OFS_WDATA: wdata_reg <= avs_writedata[DATA_W-1:0];
                    `EBR_OFS_CMD: begin
                        if (!busy) begin
                            pend <= 1'b1;
                            pend_read <= avs_writedata[`EBR_CMD_READ];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Bus clock divider, toggles every half period
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tcnt <= 8'h00;
            bus_clock_output <= 1'b0;
        end else if (tick) begin
            tcnt <= 8'h00;
            bus_clock_output <= ~bus_clock_output;
        end else begin
            tcnt <= tcnt + 8'h01;
        end
    end

    // Bus cycle sequencer, steps on bus clock rising edges
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= S_IDLE;
            wcnt <= 4'h0;
            rwait_cnt <= 8'h00;
            rwait_last <= 8'h00;
            cyc_read <= 1'b0;
            cyc_rwd <= 1'b0;
            cyc_mux <= 1'b0;
            cyc_tri <= 1'b0;
            cyc_rdyen <= 1'b0;
            cyc_wait <= 4'h0;
            cmd_due <= 1'b0;
            rdata_reg <= {DATA_W{1'b0}};
            ext_addr <= {ADDR_W{1'b0}};
            ext_data_out <= {DATA_W{1'b0}};
            ext_data_oe_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            read_chip_select_n <= 1'b1;
            write_chip_select_n <= 1'b1;
            chip_select_line_n <= 1'b1;
        end else if (rise_tick) begin
            case (state)
                // Launch: address, chip select and write data out
                S_IDLE: begin
                    if (pend) begin
                        cyc_read <= pend_read;
                        cyc_rwd <= cfg[`EBR_CFG_RWDLY];
                        cyc_mux <= cfg[`EBR_CFG_MUX];
                        cyc_tri <= cfg[`EBR_CFG_TRI];
                        cyc_rdyen <= cfg[`EBR_CFG_RDYEN];
                        cyc_wait <= cfg[`EBR_CFG_WAIT_MSB:`EBR_CFG_WAIT_LSB];
                        ext_addr <= addr_reg;
                        ext_data_out <= wdata_reg;
                        ext_data_oe_n <= pend_read;
                        chip_select_line_n <= 1'b0;
                        state <= S_ADDR;
                    end
                end
                // Address phase, command now or half a period later
                S_ADDR: begin
                    wcnt <= 4'h0;
                    rwait_cnt <= 8'h00;
                    state <= S_CMD;
                    if (cyc_rwd) begin
                        cmd_due <= 1'b1;
                    end else begin
                        rd_n <= ~cyc_read;
                        wr_n <= cyc_read;
                        read_chip_select_n <= ~cyc_read;
                        write_chip_select_n <= cyc_read;
                    end
                end
                // Command phase: memory waits, then ready samples
                S_CMD: begin
                    if (wcnt != cyc_wait) begin
                        wcnt <= wcnt + 4'h1;
                    end else if (cyc_rdyen && ready_s) begin
                        rwait_cnt <= rwait_cnt + 8'h01;
                    end else begin
                        if (cyc_read) begin
                            rdata_reg <= data_s;
                        end
                        rwait_last <= rwait_cnt;
                        ext_addr <= {ADDR_W{1'b0}};
                        ext_data_oe_n <= 1'b1;
                        rd_n <= 1'b1;
                        wr_n <= 1'b1;
                        read_chip_select_n <= 1'b1;
                        write_chip_select_n <= 1'b1;
                        chip_select_line_n <= 1'b1;
                        if (cyc_mux) begin
                            state <= S_MUX;
                        end else if (cyc_tri) begin
                            state <= S_TRI;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                end
                // Multiplex wait, then optional tristate wait
                S_MUX: begin
                    state <= cyc_tri ? S_TRI : S_IDLE;
                end
                // Tristate wait
                S_TRI: begin
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end else if (fall_tick && cmd_due) begin
            cmd_due <= 1'b0;
            rd_n <= ~cyc_read;
            wr_n <= cyc_read;
            read_chip_select_n <= ~cyc_read;
            write_chip_select_n <= cyc_read;
        end
    end
endmodule

// [rtl/ebr_regs.vh]
// Constants for the external bus ready and wait control block
// How it works
// - Ready high at sample adds one wait
// - Ready low at sample ends the cycle
// - Read data caught on address-change edge
// - Programmed length plus memory wait states first
// - Command start depends on read/write delay
// - Multiplexed mode appends multiplex wait, optional tristate
// - Multiplexed with tristate waits two bus clocks
// - Demultiplexed without tristate adds no gap
`ifndef EBR_REGS_VH
`define EBR_REGS_VH

// Register byte offsets
`define EBR_OFS_CFG 5'h00
`define EBR_OFS_ADDR 5'h04
`define EBR_OFS_WDATA 5'h08
`define EBR_OFS_CMD 5'h0C
`define EBR_OFS_RDATA 5'h10
`define EBR_OFS_STATUS 5'h14

// Configuration field positions
`define EBR_CFG_WAIT_LSB 0
`define EBR_CFG_WAIT_MSB 3
`define EBR_CFG_RWDLY 4
`define EBR_CFG_MUX 5
`define EBR_CFG_TRI 6
`define EBR_CFG_RDYEN 7

// Command and status field positions
`define EBR_CMD_READ 0
`define EBR_ST_BUSY 0
`define EBR_ST_PEND 1
`define EBR_ST_RWAIT_LSB 8
`define EBR_ST_RWAIT_MSB 15

// Reset values
`define EBR_CFG_RST 32'h00000080
`define EBR_ADDR_RST 32'h00000000
`define EBR_WDATA_RST 32'h00000000

// Timing: half bus clock period in reference clock cycles
`define EBR_HALF_PERIOD_CYC 1
// Least low time that async ready must meet, and its cycle count
`define EBR_CLK_MHZ 100
`define EBR_RDY_LOW_NS 35
`define EBR_RDY_LOW_CYC ((`EBR_RDY_LOW_NS * `EBR_CLK_MHZ + 999) / 1000)

`endif

// [rtl/ebr_sync.v]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ebr_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire ref_clk,
    input wire rstn,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    // First stage, read only by the second
    reg [W-1:0] meta;

    // Two stages, reset to a constant
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// [verif/ebr_mem_model.sv]
// Behavioural memory on the far side of the external bus
`timescale 1ns/1ps
module ebr_mem_model (
    input wire ref_clk,
    input wire bus_clock_output,
    input wire [23:0] ext_addr,
    input wire [15:0] ext_data_out,
    input wire rd_n,
    input wire wr_n,
    input wire chip_select_line_n,
    input wire [1:0] lat,
    output reg ready_n = 1'b1,
    output reg [15:0] ext_data_in = 16'hA5A5
);
    reg [15:0] mem [0:15]; // Small storage
    reg [2:0] edges = 3'h0; // Bus clock rises seen in this cycle
    reg bclk_q = 1'b0; // Bus clock one cycle ago
    // Answer once a strobe is low and lat bus clock rises have passed since chip select fell
    always @(posedge ref_clk) begin
        bclk_q <= bus_clock_output;
        if (chip_select_line_n) begin
            edges <= 3'h0;
            ready_n <= 1'b1;
        end else if (bus_clock_output && !bclk_q) begin
            edges <= edges + 3'h1;
            // ready held low until cycle end
            if (edges >= {1'b0, lat} && !(rd_n && wr_n)) ready_n <= 1'b0;
        end
        if (!wr_n) mem[ext_addr[3:0]] <= ext_data_out;
        // Released lines toggle so stale data is never seen
        ext_data_in <= !rd_n ? mem[ext_addr[3:0]] : ~ext_data_in;
    end
endmodule

// [verif/ebr_monitor.sv]
// Port checker for the external bus controller
`timescale 1ns/1ps
module ebr_monitor (
    input wire ref_clk,
    input wire rstn,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire rd_n,
    input wire wr_n,
    input wire chip_select_line_n,
    input wire ready_n
);
    // All checks run on the reference clock
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Ready held high long enough to pass the synchroniser
    sequence s_rdy_high;
        ready_n [*3];
    endsequence
    // Some command strobe is low
    sequence s_cmd_low;
        !(rd_n && wr_n);
    endsequence
    a_req_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("register request not answered next cycle");
    a_wait_one_cycle: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_high_ready_waits: assert property (s_rdy_high ##0 s_cmd_low |=> s_cmd_low)
        else $error("cycle ended while ready was high");
    a_low_ready_ends: assert property (!chip_select_line_n && !ready_n |-> ##[0:48] chip_select_line_n)
        else $error("cycle not ended after ready low");
    a_cs_frames_cmd: assert property (s_cmd_low |-> !chip_select_line_n)
        else $error("command strobe outside chip select");
    a_one_strobe: assert property (rd_n || wr_n)
        else $error("read and write strobes low together");
    a_cmd_after_cs: assert property ($fell(chip_select_line_n) |-> (rd_n && wr_n) [*2])
        else $error("command strobe too early in cycle");
    a_idle_gap: assert property ($rose(chip_select_line_n) |=> chip_select_line_n)
        else $error("next cycle started without idle bus edge");
endmodule
bind ebr_bus_ctrl ebr_monitor i_ebr_monitor (.ref_clk(ref_clk), .rstn(rstn),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .rd_n(rd_n), .wr_n(wr_n), .chip_select_line_n(chip_select_line_n), .ready_n(ready_n));

// [verif/testbench.sv]
// Self-checking bench for the external bus controller
`timescale 1ns/1ps
module testbench;
    reg ref_clk = 1'b0;
    reg rstn = 1'b0;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [4:0] avs_address = 5'h00;
    reg [31:0] avs_writedata = 32'h00000000;
    reg [1:0] lat = 2'h0; // Responder latency in bus clocks
    wire [31:0] avs_readdata;
    wire avs_waitrequest, bus_clock_output, ext_data_oe_n, rd_n, wr_n;
    wire rcs_n, wcs_n, cs_n, ready_n;
    wire [23:0] ext_addr;
    wire [15:0] ext_data_out, ext_data_in;
    int miscompares = 0;
    int check_count = 0;
    int cs_len = 0; // Cycles with chip select low
    int min_len = 0; // Shortest legal cycle
    int lead = 0; // Cycles from chip select to command
    int lead_exp = 0; // Expected command lead
    int cyc = 0; // Reference clock edge count
    int end_cyc = 0; // Edge count at which the last cycle ended
    int rd_cyc = 0; // Edge count whose state the last read shows
    logic exp_rd = 1'b0; // Expected direction of the running cycle
    logic [23:0] exp_addr = 24'h000000; // Expected cycle address
    logic shape_bad = 1'b0; // Strobe, enable or address seen wrong
    logic [31:0] exp_q[$]; // Expected read words
    logic [31:0] mask_q[$]; // Bits that matter
    logic [31:0] rd;
    logic [15:0] seed = 16'h7A78;
    ebr_bus_ctrl i_ebr_bus_ctrl (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .bus_clock_output(bus_clock_output), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
        .ext_data_oe_n(ext_data_oe_n), .ext_data_in(ext_data_in), .rd_n(rd_n), .wr_n(wr_n),
        .read_chip_select_n(rcs_n), .write_chip_select_n(wcs_n),
        .chip_select_line_n(cs_n), .ready_n(ready_n));
    ebr_mem_model i_ebr_mem_model (.ref_clk(ref_clk), .bus_clock_output(bus_clock_output),
        .ext_addr(ext_addr), .ext_data_out(ext_data_out), .rd_n(rd_n), .wr_n(wr_n),
        .chip_select_line_n(cs_n), .lat(lat), .ready_n(ready_n), .ext_data_in(ext_data_in));
    // Clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Edge counter for gap timing
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
    end
    // Pseudo-random source
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic test_done;
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // One register access; reads note the expected word first
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
        input logic [31:0] m);
        int n;
        // Let an edge pass so a released request never rises in the same step
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        if (!wr && m != 32'h0) begin
            exp_q.push_back(d & m);
            mask_q.push_back(m);
        end
        // Hold the request until waitrequest is seen low at a rising edge
        for (n = 0; n < 100; n++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        rd_cyc = cyc - 1;
        if (n == 100) begin
            miscompares++;
            test_done();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Poll status until the bus cycle is over
    task automatic wait_idle(input int gap);
        int n;
        int last_busy;
        last_busy = -1;
        for (n = 0; n < 100; n++) begin
            bus(0, 5'h14, 32'h0, 32'h0);
            if (rd[0] === 1'b0) break;
            last_busy = rd_cyc;
        end
        if (n == 100) begin
            miscompares++;
            test_done();
        end
        // Idle no sooner and no later than the trailing gap allows
        check(32'(rd_cyc >= end_cyc + gap), 32'h1);
        check(32'(last_busy < end_cyc + gap), 32'h1);
    endtask
    // Compare each read answer with the oldest note
    always @(negedge ref_clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            check(avs_readdata & mask_q.pop_front(), exp_q.pop_front());
    end
    // Length, command lead and shape of each external cycle
    always @(negedge ref_clk) begin
        if (cs_n === 1'b0) begin
            cs_len++;
            if (rd_n === 1'b1 && wr_n === 1'b1) lead++;
            if (rcs_n !== rd_n || wcs_n !== wr_n || ext_data_oe_n !== exp_rd
                || ext_addr !== exp_addr || (exp_rd ? wr_n : rd_n) !== 1'b1) shape_bad = 1'b1;
        end else if (cs_len > 0) begin
            end_cyc = cyc;
            check(32'(cs_len >= min_len), 32'h1);
            check(32'(lead), 32'(lead_exp));
            check({31'h0, shape_bad}, 32'h0);
            cs_len = 0;
            lead = 0;
            shape_bad = 1'b0;
        end
    end
    // Main sequence
    initial begin
        int i, w, gap;
        logic [15:0] data;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        bus(0, 5'h00, 32'h80, 32'hFFFFFFFF);
        bus(0, 5'h04, 32'h0, 32'hFFFFFFFF);
        bus(0, 5'h08, 32'h0, 32'hFFFFFFFF);
        bus(0, 5'h14, 32'h0, 32'hFFFF);
        bus(0, 5'h18, 32'h0, 32'hFFFFFFFF);
        // All eight delay, multiplex and tristate modes, ready always enabled, with random waits, latency and data
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            w = (seed[3:0] > seed[5:4]) ? seed[3:0] : seed[5:4];
            min_len = 2 * (2 + w);
            // Command one bus clock or one and a half after chip select
            lead_exp = 2 + (i & 1);
            // Multiplex and tristate waits each add one bus clock
            gap = 2 * (((i >> 1) & 1) + ((i >> 2) & 1));
            exp_addr = 24'(i);
            lat <= seed[5:4];
            data = lfsr(seed);
            bus(1, 5'h00, 32'h80 | (i << 4) | seed[3:0], 32'h0);
            bus(0, 5'h00, 32'h80 | (i << 4) | seed[3:0], 32'hFF);
            bus(1, 5'h04, i, 32'h0);
            bus(1, 5'h08, {16'h0, data}, 32'h0);
            exp_rd = 1'b0;
            bus(1, 5'h0C, 32'h0, 32'h0);
            wait_idle(gap);
            exp_rd = 1'b1;
            bus(1, 5'h0C, 32'h1, 32'h0);
            wait_idle(gap);
            bus(0, 5'h10, {16'h0, data}, 32'hFFFF);
        end
        test_done();
    end
endmodule
